// *** include/smsa_pkg.sv ***
package smsa_pkg;

  // APB register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // Mode, assignment, auto-on
  localparam logic [7:0] ADDR_STATUS = 8'h04;  // Mode, flags, alarm
  localparam logic [7:0] ADDR_ALARM  = 8'h08;  // Alarm cause inputs and panel clear
  localparam logic [7:0] ADDR_LIMIT0 = 8'h10;  // First of eight speed limits
  localparam int         NUM_LIMITS  = 8;      // Internal speed limits 0..7

  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;  // control_mode_parameter, 4 bits
  localparam int CTRL_MODE_W    = 4;
  localparam int CTRL_SP23_BIT  = 4;  // Speed select bits 2 and 3 assigned
  localparam int CTRL_AUTO_SVO  = 5;  // auto_on_parameter: servo-on forced
  localparam int CTRL_AUTO_FEND = 6;  // Forward stroke end forced
  localparam int CTRL_AUTO_REND = 7;  // Reverse stroke end forced

  // Alarm register fields (write)
  localparam int ALM_OC_BIT    = 0;  // Overcurrent cause present
  localparam int ALM_OL1_BIT   = 1;  // Overload 1 cause present
  localparam int ALM_OL2_BIT   = 2;  // Overload 2 cause present
  localparam int ALM_REG_BIT   = 3;  // Regenerative cause present
  localparam int ALM_PANEL_BIT = 4;  // Panel set key on alarm screen

  // Status register fields
  localparam int ST_MODE_LSB  = 0;   // Active mode, 2 bits
  localparam int ST_LIMIT_BIT = 2;   // Speed-limiting flag
  localparam int ST_DIR_LSB   = 3;   // Limit direction, 2 bits
  localparam int ST_ALM_BIT   = 5;   // Alarm active
  localparam int ST_CODE_LSB  = 8;   // Alarm code, 8 bits (BCD major)
  localparam int ST_SEL_LSB   = 16;  // Selected limit index, 3 bits

  // Control mode parameter values
  localparam logic [3:0] PMODE_POS_SPD = 4'h1;
  localparam logic [3:0] PMODE_SPD_TRQ = 4'h3;
  localparam logic [3:0] PMODE_TRQ_POS = 4'h5;

  // Alarm codes, major number in BCD; undervoltage minor digit is 1
  localparam logic [7:0] CODE_NONE  = 8'h00;
  localparam logic [7:0] CODE_UV    = 8'h10;
  localparam logic [7:0] CODE_REGEN = 8'h30;
  localparam logic [7:0] CODE_OC    = 8'h32;
  localparam logic [7:0] CODE_OL1   = 8'h50;
  localparam logic [7:0] CODE_OL2   = 8'h51;
  localparam logic [3:0] MINOR_UV   = 4'h1;

  // Debounce
  localparam int          DEB_TIME_NS = 1000;  // Stable time for contacts
  localparam int          CLK_NS      = 40;    // pclk period
  localparam int          DEB_CYC     = (DEB_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0]  DEB_MAX     = 5'(DEB_CYC);
  localparam int          NUM_IN      = 12;    // Contact input count

  // Active control mode
  typedef enum logic [1:0] {
    SMSA_POS,
    SMSA_SPD,
    SMSA_TRQ
  } smsa_mode_t;

endpackage : smsa_pkg

// *** hw/smsa_core.sv ***
// Notes on behaviour
// - Three speed selects index limits 0-7
// - Default assignment: first select picks limit 0/1
// - Direction selects choose forward or reverse limit
// - Flag speed limiting at selected limit
// - Mode 1: change input picks position/speed
// - Position changes only with zero speed at toggle
// - Position to speed clears droop pulses
// - Mode 3: change input picks speed/torque
// - Speed/torque change accepted any time
// - Starts off after speed entry: decelerate stop
// - Mode 5: change input picks torque/position
// - Position to torque clears droop, needs zero
// - Auto-on forces servo-on and stroke ends
// - Alarm shuts power stage off immediately
// - Alarm cleared by reset edge, restart, panel
// - Reset refused while cause persists
// - Codes: overcurrent 32, overloads 50/51, regen 30
// - Supply recovery raises undervoltage 10.1
// - Command pulses ignored during alarm
//
// Chosen here: the APB slave port and the register addresses.
module smsa_core (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 speed_select_bit1,
  input  wire logic                 speed_select_bit2,
  input  wire logic                 speed_select_bit3,
  input  wire logic                 forward_direction_select,
  input  wire logic                 reverse_direction_select,
  input  wire logic                 control_change_input,
  input  wire logic                 servo_on_input,
  input  wire logic                 forward_stroke_end_input,
  input  wire logic                 reverse_stroke_end_input,
  input  wire logic                 alarm_reset_input,
  input  wire logic                 forward_rotation_start,
  input  wire logic                 reverse_rotation_start,
  input  wire logic                 zero_speed_flag,
  input  wire logic                 supply_recovered,
  input  wire logic [15:0]          motor_speed,
  input  wire logic                 command_pulse_in,
  output smsa_pkg::smsa_mode_t      active_mode,
  output logic [15:0]               speed_limit,
  output logic                      limit_forward,
  output logic                      limit_reverse,
  output logic                      speed_limiting_flag,
  output logic                      droop_clear,
  output logic                      decel_stop,
  output logic                      drive_enable,
  output logic                      servo_on_eff,
  output logic                      forward_stroke_ok,
  output logic                      reverse_stroke_ok,
  output logic                      command_pulse_out,
  output logic                      alarm_active,
  output logic [7:0]                alarm_code,
  output logic [3:0]                alarm_minor
);
  import smsa_pkg::*;

  // Contact input vector: order fixed here, sync and debounce below
  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] s1, s2, s3;        // Three-stage synchroniser
  logic [NUM_IN-1:0] deb, next_deb;     // Debounced levels
  logic [4:0]        cnt [NUM_IN];      // Per-input stability counters
  logic [4:0]        next_cnt [NUM_IN];

  assign raw_in = {reverse_rotation_start, forward_rotation_start, alarm_reset_input,
                   reverse_stroke_end_input, forward_stroke_end_input, servo_on_input,
                   control_change_input, reverse_direction_select, forward_direction_select,
                   speed_select_bit3, speed_select_bit2, speed_select_bit1};

  // Debounced contact aliases
  logic sel_b1, sel_b2, sel_b3, fwd_sel, rev_sel, chg_in;
  logic svo_in, fwd_end, rev_end, alm_rst, fwd_start, rev_start;
  assign {rev_start, fwd_start, alm_rst, rev_end, fwd_end, svo_in, chg_in, rev_sel, fwd_sel,
          sel_b3, sel_b2, sel_b1} = deb;

  // Debounce: accept new level after DEB_MAX stable cycles
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      next_deb[i] = deb[i];
      next_cnt[i] = cnt[i];
      if (s2[i] != s3[i] || s3[i] == deb[i]) begin
        next_cnt[i] = '0;
      end else if (cnt[i] == DEB_MAX) begin
        next_deb[i] = s3[i];
        next_cnt[i] = '0;
      end else begin
        next_cnt[i] = cnt[i] + 5'h01;
      end
    end
  end

  // Synchroniser and debounce registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1       <= '0;
      s2       <= '0;
      s3       <= '0;
      deb      <= '0;
      for (int i = 0; i < NUM_IN; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      s1       <= raw_in;
      s2       <= s1;
      s3       <= s2;
      deb      <= next_deb;
      for (int i = 0; i < NUM_IN; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // Register file
  logic [7:0]  ctrl, next_ctrl;               // Control register
  logic [3:0]  cause, next_cause;             // Alarm cause levels
  logic        panel_clr;                     // Panel set key pulse
  logic [15:0] limits [NUM_LIMITS];           // Internal speed limits
  logic [15:0] next_limits [NUM_LIMITS];
  logic        wr_en;                         // Write in access phase
  logic [31:0] next_prdata;
  logic [31:0] status;

  assign wr_en     = psel && penable && pwrite;
  assign pready    = 1'b1;                    // Zero wait states
  assign panel_clr = wr_en && paddr == ADDR_ALARM && pwdata[ALM_PANEL_BIT];

  // Function: limit slot for an address, or NUM_LIMITS if none
  function automatic int limit_slot(input logic [7:0] a);
    int k;
    k = NUM_LIMITS;
    for (int j = 0; j < NUM_LIMITS; j++) begin
      if (a == ADDR_LIMIT0 + 8'(4 * j)) begin
        k = j;
      end
    end
    return k;
  endfunction : limit_slot

  // Register writes and read mux
  always_comb begin
    next_ctrl  = ctrl;
    next_cause = cause;
    for (int i = 0; i < NUM_LIMITS; i++) begin
      next_limits[i] = limits[i];
    end
    next_prdata = prdata;
    pslverr     = 1'b0;
    if (psel && penable) begin
      if (paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_ALARM
          || limit_slot(paddr) < NUM_LIMITS) begin
        pslverr = 1'b0;
      end else begin
        pslverr = 1'b1;                       // Unmapped address
      end
    end
    if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        next_ctrl = pwdata[7:0];
      end else if (paddr == ADDR_ALARM) begin
        next_cause = pwdata[3:0];
      end else if (limit_slot(paddr) < NUM_LIMITS) begin
        next_limits[limit_slot(paddr)] = pwdata[15:0];
      end
    end
    if (psel && !penable && !pwrite) begin
      // Capture read data in setup so it is stable in access
      if (paddr == ADDR_CTRL) begin
        next_prdata = {24'h0, ctrl};
      end else if (paddr == ADDR_STATUS) begin
        next_prdata = status;
      end else if (paddr == ADDR_ALARM) begin
        next_prdata = {28'h0, cause};
      end else if (limit_slot(paddr) < NUM_LIMITS) begin
        next_prdata = {16'h0, limits[limit_slot(paddr)]};
      end else begin
        next_prdata = '0;
      end
    end
  end

  // Register file storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= '0;
      cause  <= '0;
      prdata <= '0;
      for (int i = 0; i < NUM_LIMITS; i++) begin
        limits[i] <= '0;
      end
    end else begin
      ctrl   <= next_ctrl;
      cause  <= next_cause;
      prdata <= next_prdata;
      for (int i = 0; i < NUM_LIMITS; i++) begin
        limits[i] <= next_limits[i];
      end
    end
  end

  // Control configuration aliases
  logic [3:0] pmode;
  assign pmode = ctrl[CTRL_MODE_LSB +: CTRL_MODE_W];

  // Auto-on forcing of servo-on and stroke ends
  assign servo_on_eff      = svo_in | ctrl[CTRL_AUTO_SVO];
  assign forward_stroke_ok = fwd_end | ctrl[CTRL_AUTO_FEND];
  assign reverse_stroke_ok = rev_end | ctrl[CTRL_AUTO_REND];

  // Speed limit selection
  logic [2:0] sel;
  always_comb begin
    if (ctrl[CTRL_SP23_BIT]) begin
      sel = {sel_b3, sel_b2, sel_b1};
    end else begin
      sel = {2'b00, sel_b1};
    end
  end

  // Mode selection state
  smsa_mode_t mode, next_mode;
  logic       chg_q, next_chg_q;              // Previous change input
  logic       spd_entry, next_spd_entry;      // Speed mode just entered
  logic       droop, next_droop;
  smsa_mode_t want;                            // Mode asked by change input

  always_comb begin
    case (pmode)
      PMODE_POS_SPD: want = chg_in ? SMSA_SPD : SMSA_POS;
      PMODE_SPD_TRQ: want = chg_in ? SMSA_TRQ : SMSA_SPD;
      PMODE_TRQ_POS: want = chg_in ? SMSA_POS : SMSA_TRQ;
      default:       want = SMSA_POS;
    endcase
  end

  // Mode change sequencing
  always_comb begin
    next_mode      = mode;
    next_chg_q     = chg_in;
    next_droop     = 1'b0;
    next_spd_entry = 1'b0;
    if (pmode == PMODE_SPD_TRQ) begin
      next_mode = want;
    end else if (chg_in != chg_q && zero_speed_flag) begin
      next_mode = want;
    end else if (pmode != PMODE_POS_SPD && pmode != PMODE_TRQ_POS) begin
      next_mode = want;
    end
    if (mode == SMSA_POS && next_mode != SMSA_POS) begin
      next_droop = 1'b1;
    end
    if (mode != SMSA_SPD && next_mode == SMSA_SPD) begin
      next_spd_entry = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode      <= SMSA_POS;
      chg_q     <= 1'b0;
      droop     <= 1'b0;
      spd_entry <= 1'b0;
    end else begin
      mode      <= next_mode;
      chg_q     <= next_chg_q;
      droop     <= next_droop;
      spd_entry <= next_spd_entry;
    end
  end

  assign active_mode = mode;
  assign droop_clear = droop;
  assign decel_stop  = spd_entry && !fwd_start && !rev_start;

  // Alarm state
  logic       alm, next_alm;
  logic [7:0] code, next_code;
  logic [3:0] minor, next_minor;
  logic       alm_rst_q, next_alm_rst_q;
  logic       clr_req;

  always_comb begin
    next_alm_rst_q = alm_rst;
    clr_req        = (alm_rst && !alm_rst_q) || panel_clr;
    next_alm   = alm;
    next_code  = code;
    next_minor = minor;
    if (!alm) begin
      next_minor = 4'h0;
      if (supply_recovered) begin
        next_alm   = 1'b1;
        next_code  = CODE_UV;
        next_minor = MINOR_UV;
      end else if (cause[ALM_OC_BIT]) begin
        next_alm  = 1'b1;
        next_code = CODE_OC;
      end else if (cause[ALM_OL1_BIT]) begin
        next_alm  = 1'b1;
        next_code = CODE_OL1;
      end else if (cause[ALM_OL2_BIT]) begin
        next_alm  = 1'b1;
        next_code = CODE_OL2;
      end else if (cause[ALM_REG_BIT]) begin
        next_alm  = 1'b1;
        next_code = CODE_REGEN;
      end
    end else if (clr_req && cause == 4'h0 && !supply_recovered) begin
      next_alm   = 1'b0;
      next_code  = CODE_NONE;
      next_minor = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alm   <= 1'b0;
      code  <= CODE_NONE;
      minor <= 4'h0;
      alm_rst_q <= 1'b0;
    end else begin
      alm   <= next_alm;
      code  <= next_code;
      minor <= next_minor;
      alm_rst_q <= next_alm_rst_q;
    end
  end

  assign alarm_active = alm;
  assign alarm_code   = code;
  assign alarm_minor  = minor;
  assign drive_enable = servo_on_eff && !alm && !alm_rst;
  assign command_pulse_out = command_pulse_in && mode == SMSA_POS && !alm;

  // Speed limit output stage
  logic [15:0] lim_q, next_lim;
  logic        fwd_q, rev_q, lim_hit_q, next_fwd, next_rev, next_lim_hit;
  always_comb begin
    next_lim     = limits[sel];
    next_fwd     = mode == SMSA_TRQ && fwd_sel && !rev_sel;
    next_rev     = mode == SMSA_TRQ && !fwd_sel && rev_sel;
    next_lim_hit = mode == SMSA_TRQ && motor_speed >= limits[sel];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_q     <= '0;
      fwd_q     <= 1'b0;
      rev_q     <= 1'b0;
      lim_hit_q <= 1'b0;
    end else begin
      lim_q     <= next_lim;
      fwd_q     <= next_fwd;
      rev_q     <= next_rev;
      lim_hit_q <= next_lim_hit;
    end
  end

  assign speed_limit         = lim_q;
  assign limit_forward       = fwd_q;
  assign limit_reverse       = rev_q;
  assign speed_limiting_flag = lim_hit_q;

  assign status = {13'h0, sel, code, 2'b00, alm, rev_q, fwd_q, lim_hit_q, mode};

  // Assertions
  sequence trq_hit_s;  // Torque mode with speed at the selected limit
    mode == SMSA_TRQ && motor_speed >= limits[sel];
  endsequence
  unlit_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
    alm |-> !drive_enable) else $error("drive on during alarm");
  pulse_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    alm |-> !command_pulse_out) else $error("pulse passed in alarm");
  refuse_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (alm && cause != 4'h0) |=> alm) else $error("alarm cleared with cause");
  uv_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!alm && supply_recovered) |=> (alm && code == CODE_UV && minor == MINOR_UV))
    else $error("undervoltage not raised");
  droop_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(mode) == SMSA_POS && mode != SMSA_POS) |-> droop)
    else $error("droop not cleared");
  zero_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pmode == PMODE_POS_SPD && chg_in == chg_q && mode != want) |=> mode == $past(mode))
    else $error("mode changed without toggle");
  limit_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    trq_hit_s ##1 (mode == SMSA_TRQ) |-> lim_hit_q) else $error("limit flag missing");
  default_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[CTRL_SP23_BIT] |-> sel[2:1] == 2'b00) else $error("high select used");
  spd_trq_a: assert property (@(posedge pclk) disable iff (!presetn)
    pmode == PMODE_SPD_TRQ |=> mode == $past(want)) else $error("speed/torque late");

endmodule : smsa_core

// *** bench/smsa_panel.sv ***
// Relay panel on the far side: drives the contact inputs with chatter
module smsa_panel (
  input  wire logic        pclk,
  input  wire logic [11:0] want,
  output logic      [11:0] contact
);
  timeunit 1ns;
  timeprecision 1ps;

  int          left = 0;  // Chatter cycles still to run
  logic [11:0] chg  = '0; // Contacts that are moving

  initial contact = '0;

  // A moving contact bounces a few cycles before it rests on the new level
  always @(posedge pclk) begin
    if (left == 0 && contact !== want) begin
      left    <= 4;
      chg     <= contact ^ want;
      contact <= want;
    end else if (left > 1) begin
      left    <= left - 1;
      contact <= contact ^ chg;
    end else if (left == 1) begin
      left    <= 0;
      contact <= want;
    end
  end
endmodule : smsa_panel

// *** bench/tb.sv ***
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import smsa_pkg::*;

  localparam logic [11:0] B_SP = 12'h007;  // Speed select contacts
  localparam logic [11:0] B_CC = 12'h020;  // Control change contact
  localparam logic [11:0] B_RS = 12'h200;  // Alarm reset contact

  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, zs = 0, sup = 0, cpi = 0;
  logic [15:0] ms = '0, speed_limit, v;
  logic [15:0] lim [8];                    // Programmed limits
  logic [7:0]  codes [4] = '{8'h32, 8'h50, 8'h51, 8'h30};
  logic [11:0] want = '0, ct;              // Requested and actual contacts
  logic        lf, lr, vflag, droop, dec, drv, svo, fok, rok, cpo, alm;
  logic [7:0]  code;
  logic [3:0]  minor;
  smsa_mode_t  active_mode;
  int          num_errors = 0, checks = 0, n_droop = 0, n_dec = 0, d, e;

  always #20 pclk = ~pclk;

  smsa_panel u_panel (.pclk(pclk), .want(want), .contact(ct));

  smsa_core u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_select_bit1(ct[0]), .speed_select_bit2(ct[1]), .speed_select_bit3(ct[2]),
    .forward_direction_select(ct[3]), .reverse_direction_select(ct[4]),
    .control_change_input(ct[5]), .servo_on_input(ct[6]), .forward_stroke_end_input(ct[7]),
    .reverse_stroke_end_input(ct[8]), .alarm_reset_input(ct[9]),
    .forward_rotation_start(ct[10]), .reverse_rotation_start(ct[11]),
    .zero_speed_flag(zs), .supply_recovered(sup), .motor_speed(ms), .command_pulse_in(cpi),
    .active_mode(active_mode), .speed_limit(speed_limit), .limit_forward(lf),
    .limit_reverse(lr), .speed_limiting_flag(vflag), .droop_clear(droop), .decel_stop(dec),
    .drive_enable(drv), .servo_on_eff(svo), .forward_stroke_ok(fok), .reverse_stroke_ok(rok),
    .command_pulse_out(cpo), .alarm_active(alm), .alarm_code(code), .alarm_minor(minor));

  // Count the one-cycle pulses
  always @(posedge pclk) begin
    if (droop === 1'b1) n_droop <= n_droop + 1;
    if (dec === 1'b1) n_dec <= n_dec + 1;
  end

  // Expected limit index from the contacts
  function automatic int sel_of(logic [11:0] w, logic wide);
    return wide ? int'(w[2:0]) : int'(w[0]);
  endfunction : sel_of

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    @(posedge pclk);
    psel   <= 1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask : apb

  // Move the masked contacts
  task automatic put(input logic [11:0] m, input logic [11:0] val);
    @(posedge pclk);
    want <= (want & ~m) | (val & m);
  endtask : put

  // Wait, then sample on the falling edge
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : wt

  task automatic give_verdict;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    give_verdict;
  end

  // Main sequence
  initial begin
    rd = $urandom(38017);
    repeat (16) @(posedge pclk);
    presetn <= 1;
    // Auto-on forcing with every contact off
    apb(1, ADDR_CTRL, 32'he0);
    wt(2);
    `CHK({svo, fok, rok}, 3'b111)
    apb(1, ADDR_CTRL, 32'h20);
    wt(2);
    `CHK({svo, fok, rok}, 3'b100)
    @(posedge pclk);
    cpi <= 1;
    wt(2);
    `CHK({drv, cpo}, 2'b11)
    // Each alarm cause, a refused clear, then a real clear
    for (int k = 0; k < 4; k++) begin
      apb(1, ADDR_ALARM, 32'(1 << k));
      wt(2);
      `CHK({alm, drv, cpo, code}, {3'b100, codes[k]})
      apb(1, ADDR_ALARM, 32'(1 << k) | 32'h10);
      wt(2);
      `CHK(alm, 1'b1)
      apb(1, ADDR_ALARM, 32'h0);
      if (k[0]) apb(1, ADDR_ALARM, 32'h10);
      else begin
        put(B_RS, B_RS);
        wt(45);
        put(B_RS, 12'h0);
      end
      wt(45);
      `CHK({alm, drv, cpo}, 3'b011)
    end
    @(posedge pclk);
    sup <= 1;
    @(posedge pclk);
    sup <= 0;
    wt(2);
    `CHK({alm, code, minor}, {1'b1, 8'h10, 4'h1})
    apb(1, ADDR_ALARM, 32'h10);
    wt(2);
    `CHK(alm, 1'b0)
    // Position and speed change, gated by zero speed at the toggle
    apb(1, ADDR_CTRL, 32'h21);
    put(B_CC, B_CC);
    wt(45);
    `CHK(active_mode, SMSA_POS)
    @(posedge pclk);
    zs <= 1;
    wt(45);
    `CHK(active_mode, SMSA_POS)
    put(B_CC, 12'h0);
    wt(45);
    d = n_droop;
    e = n_dec;
    put(B_CC, B_CC);
    wt(45);
    `CHK(active_mode, SMSA_SPD)
    `CHK(n_droop, d + 1)
    `CHK(n_dec, e + 1)
    // Torque and position change
    apb(1, ADDR_CTRL, 32'h25);
    put(B_CC, 12'h0);
    wt(45);
    put(B_CC, B_CC);
    wt(45);
    `CHK(active_mode, SMSA_POS)
    @(posedge pclk);
    zs <= 0;
    put(B_CC, 12'h0);
    wt(45);
    `CHK(active_mode, SMSA_POS)
    @(posedge pclk);
    zs <= 1;
    put(B_CC, B_CC);
    wt(45);
    d = n_droop;
    put(B_CC, 12'h0);
    wt(45);
    `CHK(active_mode, SMSA_TRQ)
    `CHK(n_droop, d + 1)
    // Limits clear of both ends of the 16-bit range
    for (int i = 0; i < 8; i++) begin
      lim[i] = 16'($urandom_range(16'hfff0, 16'h0100));
      apb(1, ADDR_LIMIT0 + 8'(4 * i), {16'h0, lim[i]});
      apb(0, ADDR_LIMIT0 + 8'(4 * i), 32'h0);
      `CHK(rd[15:0], lim[i])
    end
    apb(0, 8'h30, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // Speed and torque change with no zero speed
    @(posedge pclk);
    zs <= 0;
    apb(1, ADDR_CTRL, 32'h33);
    put(B_CC, B_CC);
    wt(45);
    `CHK(active_mode, SMSA_TRQ)
    for (int i = 0; i < 8; i++) begin
      put(B_SP, 12'(i));
      wt(45);
      `CHK(speed_limit, lim[sel_of(want, 1'b1)])
      v = lim[i] + 16'($urandom_range(2)) - 16'd1;
      @(posedge pclk);
      ms <= v;
      wt(3);
      `CHK(vflag, (v >= lim[i]))
      apb(0, ADDR_STATUS, 32'h0);
      `CHK({rd[18:16], rd[1:0]}, {3'(i), 2'd2})
    end
    for (int i = 1; i < 3; i++) begin
      put(12'h018, 12'(i << 3));
      wt(45);
      `CHK({lf, lr}, {i[0], i[1]})
    end
    // Default assignment: only the first select contact counts
    apb(1, ADDR_CTRL, 32'h23);
    for (int j = 0; j < 2; j++) begin
      put(B_SP, 12'h6 | 12'(j));
      wt(45);
      `CHK(speed_limit, lim[sel_of(want, 1'b0)])
    end
    e = n_dec;
    put(B_CC, 12'h0);
    wt(45);
    `CHK(active_mode, SMSA_SPD)
    `CHK(n_dec, e + 1)
    give_verdict;
  end
endmodule : tb
